// [design/erb_regs.vh]
`ifndef ERB_REGS_VH
`define ERB_REGS_VH

// Register byte offsets
`define ERB_CFG_OFS 8'h00
`define ERB_STAT_OFS 8'h04
`define ERB_LDADDR_OFS 8'h08
`define ERB_LDDATA_OFS 8'h0C

// Configuration fields
`define ERB_CFG_W 29
`define ERB_CFG_RST 29'h0000_0780
`define ERB_MODE_LSB 0
`define ERB_ASP_LSB 2
`define ERB_DREG_BIT 4
`define ERB_AREG_BIT 5
`define ERB_OREG_BIT 6
`define ERB_ICLK_LSB 7
`define ERB_OCLK_LSB 9
`define ERB_WESEL_BIT 11
`define ERB_WECH_LSB 12
`define ERB_ICH_LSB 17
`define ERB_OCH_LSB 22
`define ERB_ROW_BIT 27
`define ERB_COL_BIT 28

// Modes
`define ERB_MODE_SP 2'h0
`define ERB_MODE_DP 2'h1
`define ERB_MODE_FIFO 2'h2
`define ERB_MODE_ROM 2'h3

// Clock sources
`define ERB_CK_GLB 2'h0
`define ERB_CK_PIN 2'h1
`define ERB_CK_LOC 2'h2
`define ERB_CK_FREE 2'h3

// Status fields
`define ERB_EMPTY_BIT 0
`define ERB_FULL_BIT 1
`define ERB_CNT_LSB 2

`endif

// [design/erb_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "erb_regs.vh"

module erb_top #(
  parameter LOCAL_CHANNELS = 22
)(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire glb_clk,
  input wire clk_pin,
  input wire glb_we,
  input wire [LOCAL_CHANNELS-1:0] local_route,
  input wire blk_sel,
  input wire [10:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [10:0] rd_addr,
  input wire rd_en,
  output reg [7:0] rd_data,
  output reg [15:0] row_out,
  output reg [15:0] col_out,
  output reg fifo_empty,
  output reg fifo_full
);

  function [10:0] erb_dmask;
    input [1:0] k;
    begin
      case (k)
        2'h0: erb_dmask = 11'h0FF;
        2'h1: erb_dmask = 11'h1FF;
        2'h2: erb_dmask = 11'h3FF;
        default: erb_dmask = 11'h7FF;
      endcase
    end
  endfunction

  function [7:0] erb_bmask;
    input [1:0] k;
    begin
      case (k)
        2'h0: erb_bmask = 8'hFF;
        2'h1: erb_bmask = 8'h0F;
        2'h2: erb_bmask = 8'h03;
        default: erb_bmask = 8'h01;
      endcase
    end
  endfunction

  // Bit position of a word in the 2048-bit array
  function [10:0] erb_pos;
    input [10:0] a;
    input [1:0] k;
    reg [13:0] p;
    begin
      p = {a, 3'h0} >> k;
      erb_pos = p[10:0];
    end
  endfunction

  function erb_tick;
    input [1:0] sel;
    input g;
    input p;
    input l;
    begin
      case (sel)
        `ERB_CK_GLB: erb_tick = g;
        `ERB_CK_PIN: erb_tick = p;
        `ERB_CK_LOC: erb_tick = l;
        default: erb_tick = 1'b1;
      endcase
    end
  endfunction

  reg [`ERB_CFG_W-1:0] cfg;
  reg [7:0] mem [0:255];
  reg [7:0] ld_ptr;
  reg ap_wr;
  reg ap_rd;
  reg [7:0] ap_ofs;
  reg [7:0] data_q;
  reg [10:0] addr_q;
  reg we_q;
  reg [10:0] wptr;
  reg [10:0] rptr;
  reg [11:0] count;
  reg loc_in_q;
  reg loc_out_q;
  reg [7:0] next_rd;
  reg [31:0] next_hrdata;
  wire [1:0] ext_in;
  wire [1:0] ext_rise;

  wire [1:0] mode = cfg[`ERB_MODE_LSB +: 2];
  wire [1:0] asp = cfg[`ERB_ASP_LSB +: 2];
  wire dreg = cfg[`ERB_DREG_BIT];
  wire areg = cfg[`ERB_AREG_BIT];
  wire oreg = cfg[`ERB_OREG_BIT];
  wire [4:0] we_ch = cfg[`ERB_WECH_LSB +: 5];
  wire [4:0] in_ch = cfg[`ERB_ICH_LSB +: 5];
  wire [4:0] out_ch = cfg[`ERB_OCH_LSB +: 5];
  wire is_fifo = (mode == `ERB_MODE_FIFO);
  wire is_rom = (mode == `ERB_MODE_ROM);
  wire [10:0] dmask = erb_dmask(asp);
  wire [7:0] bmask = erb_bmask(asp);
  wire [11:0] depth = {1'b0, dmask} + 12'h001;

  assign ext_in = {clk_pin, glb_clk};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg lvl;
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
        end
        else
        begin
          s1 <= ext_in[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            lvl <= s3;
        end
      end
      assign ext_rise[gi] = (s2 == s3) & s3 & ~lvl;
    end
  endgenerate

  // local channel pick, out of range reads low
  wire loc_in = (in_ch < LOCAL_CHANNELS) ? local_route[in_ch] : 1'b0;
  wire loc_out = (out_ch < LOCAL_CHANNELS) ? local_route[out_ch] : 1'b0;
  wire loc_we = (we_ch < LOCAL_CHANNELS) ? local_route[we_ch] : 1'b0;

  wire in_tick = erb_tick(cfg[`ERB_ICLK_LSB +: 2], ext_rise[0],
    ext_rise[1], loc_in & ~loc_in_q);
  wire out_tick = erb_tick(cfg[`ERB_OCLK_LSB +: 2], ext_rise[0],
    ext_rise[1], loc_out & ~loc_out_q);

  wire we_live = cfg[`ERB_WESEL_BIT] ? loc_we : glb_we;

  wire [7:0] din = dreg ? data_q : wr_data;
  wire [10:0] wa = (areg ? addr_q : wr_addr) & dmask;
  wire we_e = areg ? we_q : we_live;

  wire wr_fire = in_tick & we_e & blk_sel & ~is_rom &
    ~(is_fifo & fifo_full);
  wire pop = out_tick & rd_en & blk_sel & is_fifo & ~fifo_empty;

  wire [10:0] waddr = is_fifo ? wptr : wa;
  wire [10:0] raddr = is_fifo ? rptr :
    ((mode == `ERB_MODE_SP) ? wa : (rd_addr & dmask));

  wire [10:0] wpos = erb_pos(waddr, asp);
  wire [10:0] rpos = erb_pos(raddr, asp);
  wire [7:0] wmask = bmask << wpos[2:0];
  wire [7:0] wbits = (din & bmask) << wpos[2:0];
  wire [7:0] rbyte = mem[rpos[10:3]] >> rpos[2:0];
  wire [7:0] lookup = rbyte & bmask;

  wire take = hsel & hready & htrans[1];
  wire ld_we = ap_wr & (ap_ofs == `ERB_LDDATA_OFS);
  wire cfg_we = ap_wr & (ap_ofs == `ERB_CFG_OFS);
  wire [11:0] next_count = count + {11'h000, wr_fire} -
    {11'h000, pop};

  // configuration load wins over user write
  always @(posedge hclk)
  begin
    if (ld_we)
      mem[ld_ptr] <= hwdata[7:0];
    else if (wr_fire)
      mem[wpos[10:3]] <= (mem[wpos[10:3]] & ~wmask) | wbits;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_q <= 8'h00;
      addr_q <= 11'h000;
      we_q <= 1'b0;
      loc_in_q <= 1'b0;
      loc_out_q <= 1'b0;
    end
    else
    begin
      loc_in_q <= loc_in;
      loc_out_q <= loc_out;
      if (in_tick)
      begin
        data_q <= wr_data;
        addr_q <= wr_addr;
        we_q <= we_live;
      end
    end
  end

  // FIFO pointers, cleared by a config write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wptr <= 11'h000;
      rptr <= 11'h000;
      count <= 12'h000;
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
    end
    else if (cfg_we)
    begin
      wptr <= 11'h000;
      rptr <= 11'h000;
      count <= 12'h000;
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
    end
    else if (is_fifo)
    begin
      if (wr_fire)
        wptr <= (wptr + 11'h001) & dmask;
      if (pop)
        rptr <= (rptr + 11'h001) & dmask;
      count <= next_count;
      fifo_empty <= (next_count == 12'h000);
      fifo_full <= (next_count == depth);
    end
  end

  always @*
  begin
    next_rd = rd_data;
    if (!blk_sel)
      next_rd = 8'h00;
    else if (!oreg || out_tick)
      next_rd = lookup;
  end

  // two row and two column copies
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_data <= 8'h00;
      row_out <= 16'h0000;
      col_out <= 16'h0000;
    end
    else
    begin
      rd_data <= next_rd;
      row_out <= cfg[`ERB_ROW_BIT] ? {next_rd, next_rd} : 16'h0000;
      col_out <= cfg[`ERB_COL_BIT] ? {next_rd, next_rd} : 16'h0000;
    end
  end

  always @*
  begin
    case (ap_ofs)
      `ERB_CFG_OFS: next_hrdata = {3'h0, cfg};
      `ERB_STAT_OFS: next_hrdata = {18'h00000, count, fifo_full,
        fifo_empty};
      `ERB_LDADDR_OFS: next_hrdata = {24'h000000, ld_ptr};
      `ERB_LDDATA_OFS: next_hrdata = {24'h000000, mem[ld_ptr]};
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: writes no wait, reads one wait
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_ofs <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      cfg <= `ERB_CFG_RST;
      ld_ptr <= 8'h00;
    end
    else
    begin
      hresp <= 1'b0;
      ap_wr <= take & hwrite;
      ap_rd <= take & ~hwrite;
      hreadyout <= ~(take & ~hwrite);
      if (take)
        ap_ofs <= haddr[7:0];
      if (ap_rd)
        hrdata <= next_hrdata;
      if (cfg_we)
        cfg <= hwdata[`ERB_CFG_W-1:0];
      if (ap_wr && ap_ofs == `ERB_LDADDR_OFS)
        ld_ptr <= hwdata[7:0];
      else if (ld_we)
        ld_ptr <= ld_ptr + 8'h01;
    end
  end

endmodule
`default_nettype wire

// [testbench/configurable_embedded_ram_block_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module configurable_embedded_ram_block_tb;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic blk_sel = 1'h1;
  logic rd_en = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [21:0] local_route = 22'h0;
  logic [10:0] rd_addr = 11'h0;
  logic glb_clk = 1'h0;
  logic clk_pin = 1'h0;
  wire hreadyout, hresp, fifo_empty, fifo_full, glb_we;
  wire [31:0] hrdata;
  wire [7:0] rd_data, wr_data;
  wire [15:0] row_out, col_out;
  wire [10:0] wr_addr;
  int failures = 0;
  int total_checks = 0;
  erb_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .glb_clk, .clk_pin, .glb_we, .local_route, .blk_sel,
    .wr_addr, .wr_data, .rd_addr, .rd_en, .rd_data, .row_out, .col_out,
    .fifo_empty, .fifo_full);
  erb_fabric i_fab (.hclk, .wr_addr, .wr_data, .glb_we);
  initial forever #5 hclk = ~hclk;
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge hclk); while (hreadyout !== 1'h1);
    @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'h1);
    rv = hrdata;
  endtask
  task settle;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  task t_reset;
    chk("fifo_empty", fifo_empty, 32'h1);
    chk("rd_data", rd_data, 32'h0);
    ahb(1'h0, 8'h00, 32'h0);
    chk("cfg", rv, 32'h780);
    $display("reset test done");
  endtask
  task t_aspect;
    for (int a = 0; a < 4; a++)
    begin
      ahb(1'h1, 8'h00, 32'h781 | (a << 2));
      i_fab.put(11'h005, 8'hFF);
      i_fab.put(11'h004, 8'h00);
      rd_addr <= 11'h005;
      settle;
      chk("word", rd_data, 32'hFF >> (8 - (8 >> a)));
    end
    $display("aspect test done");
  endtask
  task t_cascade;
    @(posedge hclk);
    blk_sel <= 1'h0;
    i_fab.put(11'h005, 8'h00);
    settle;
    chk("deselected", rd_data, 32'h0);
    @(posedge hclk);
    blk_sel <= 1'h1;
    settle;
    chk("kept", rd_data, 32'h1);
    $display("cascade test done");
  endtask
  task t_load;
    ahb(1'h1, 8'h08, 32'h10);
    ahb(1'h1, 8'h0C, 32'h5A);
    ahb(1'h0, 8'h08, 32'h0);
    chk("ldptr", rv, 32'h11);
    ahb(1'h1, 8'h08, 32'h10);
    ahb(1'h0, 8'h0C, 32'h0);
    chk("load", rv, 32'h5A);
    ahb(1'h0, 8'h20, 32'h0);
    chk("unmapped", rv, 32'h0);
    ahb(1'h1, 8'h00, 32'h783);
    @(posedge hclk);
    rd_addr <= 11'h010;
    i_fab.put(11'h010, 8'h00);
    settle;
    chk("rom", rd_data, 32'h5A);
    ahb(1'h1, 8'h00, 32'h0800_0780);
    i_fab.put(11'h021, 8'h3C);
    settle;
    chk("single", rd_data, 32'h3C);
    chk("row_out", row_out, 32'h3C3C);
    chk("col_out", col_out, 32'h0);
    $display("load test done");
  endtask
  task t_clocks;
    ahb(1'h1, 8'h00, 32'h781);
    i_fab.put(11'h030, 8'h11);
    rd_addr <= 11'h030;
    ahb(1'h1, 8'h00, 32'h681);
    i_fab.hold(11'h030, 8'h22, 1'h1);
    settle;
    chk("no pin edge", rd_data, 32'h11);
    @(posedge hclk);
    clk_pin <= 1'h1;
    repeat (6) @(posedge hclk);
    clk_pin <= 1'h0;
    i_fab.hold(11'h030, 8'h22, 1'h0);
    settle;
    chk("pin clock", rd_data, 32'h22);
    ahb(1'h1, 8'h00, 32'h601);
    i_fab.hold(11'h030, 8'h33, 1'h1);
    @(posedge hclk);
    glb_clk <= 1'h1;
    repeat (6) @(posedge hclk);
    glb_clk <= 1'h0;
    i_fab.hold(11'h030, 8'h33, 1'h0);
    settle;
    chk("global clock", rd_data, 32'h33);
    $display("clock test done");
  endtask
  task t_regs;
    ahb(1'h1, 8'h00, 32'h7B1);
    i_fab.put(11'h040, 8'h66);
    rd_addr <= 11'h040;
    settle;
    chk("registered in", rd_data, 32'h66);
    ahb(1'h1, 8'h00, 32'h4005C1);
    @(posedge hclk);
    rd_addr <= 11'h030;
    settle;
    chk("held out", rd_data, 32'h66);
    @(posedge hclk);
    local_route <= 22'h000002;
    @(posedge hclk);
    local_route <= 22'h000000;
    settle;
    chk("output clock", rd_data, 32'h33);
    $display("register test done");
  endtask
  task t_fifo;
    ahb(1'h1, 8'h00, 32'h782);
    i_fab.put(11'h001, 8'hAA);
    i_fab.put(11'h002, 8'hBB);
    ahb(1'h0, 8'h04, 32'h0);
    chk("count", rv[13:0], 32'h8);
    chk("head", rd_data, 32'hAA);
    @(posedge hclk);
    rd_en <= 1'h1;
    @(posedge hclk);
    rd_en <= 1'h0;
    ahb(1'h0, 8'h04, 32'h0);
    chk("popped", rv[13:0], 32'h4);
    chk("next head", rd_data, 32'hBB);
    for (int i = 0; i < 256; i++)
      i_fab.put(11'h000, i[7:0]);
    ahb(1'h0, 8'h04, 32'h0);
    chk("full count", rv[13:0], 32'h402);
    chk("fifo_full", fifo_full, 32'h1);
    $display("fifo test done");
  endtask
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #50000;
    failures++;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(negedge hclk);
    t_reset;
    t_aspect;
    t_cascade;
    t_load;
    t_clocks;
    t_regs;
    t_fifo;
    conclude;
  end
endmodule
`default_nettype wire

// [testbench/erb_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module erb_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [7:0] rd_data,
  input wire [15:0] row_out,
  input wire [15:0] col_out,
  input wire fifo_empty,
  input wire fifo_full
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("bad response");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(take)
    && !$past(hwrite))
    else $error("stray wait");
  a_rdata_hold: assert property ($changed(hrdata) |->
    !hreadyout || !$past(hreadyout))
    else $error("hrdata moved");
  a_row_mirror: assert property (row_out == 16'h0 ||
    row_out == {rd_data, rd_data})
    else $error("row copy wrong");
  a_col_mirror: assert property (col_out == 16'h0 ||
    col_out == {rd_data, rd_data})
    else $error("col copy wrong");
  a_flag_excl: assert property (!(fifo_empty && fifo_full))
    else $error("empty and full");
endmodule
bind erb_top erb_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .rd_data, .row_out, .col_out,
  .fifo_empty, .fifo_full);
`default_nettype wire

// [testbench/erb_fabric.sv]
`timescale 1ns/1ps
`default_nettype none
module erb_fabric (
  input wire hclk,
  output logic [10:0] wr_addr,
  output logic [7:0] wr_data,
  output logic glb_we
);
  initial wr_addr = 11'h0;
  initial wr_data = 8'h0;
  initial glb_we = 1'h0;
  task put(input logic [10:0] a, input logic [7:0] d);
    @(posedge hclk);
    wr_addr <= a;
    wr_data <= d;
    glb_we <= 1'h1;
    @(posedge hclk);
    glb_we <= 1'h0;
    wr_data <= ~d;
  endtask
  task hold(input logic [10:0] a, input logic [7:0] d, input logic w);
    @(posedge hclk);
    wr_addr <= a;
    wr_data <= d;
    glb_we <= w;
  endtask
endmodule
`default_nettype wire
